// *** verilog/tda_pkg.sv ***
// constants and types of the tributary demap alignment block
// assumes a 40 MHz system clock and a bit-serial multiplex on its own clock
package tda_pkg;

  // ==========================================================
  // frame layout, positions within one 512-bit double frame
  localparam logic [6:0] FAS_WORD       = 7'h1B;
  localparam logic [5:0] MFAS_WORD      = 6'h0B;
  localparam logic [8:0] POS_DBL_START  = 9'h000;
  localparam logic [8:0] POS_FAS_END    = 9'h007;
  localparam logic [8:0] POS_NFAS_B1    = 9'h100;
  localparam logic [8:0] POS_NFAS_B2    = 9'h101;
  localparam logic [8:0] POS_RST        = 9'h000;
  localparam logic [2:0] MFA_DBL_AT_MFAS = 3'h5;
  localparam logic [1:0] FAS_LOSS_LIMIT = 2'h3;

  // ==========================================================
  // all-ones detection: X periods of Y bits, Z zeros
  localparam logic [8:0] AIS_Y_LAST = 9'h1FF;
  localparam logic [1:0] AIS_X      = 2'h2;
  localparam logic [1:0] AIS_Z      = 2'h3;

  // ==========================================================
  // timing
  localparam int         BASIC_FRAME_US     = 250;
  localparam int         MFA_TIMEOUT_US     = 8000;
  localparam logic [5:0] MFA_TIMEOUT_FRAMES = 6'(MFA_TIMEOUT_US / BASIC_FRAME_US);
  localparam int         FIFO_DEPTH         = 32;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CSM_OFF  = 2'h0,
    CSM_ON   = 2'h1,
    CSM_AUTO = 2'h2
  } tda_csm_t;

  typedef enum logic [6:0] {
    ST_OOF      = 7'h01,
    ST_NFAS_CHK = 7'h02,
    ST_FAS_CHK  = 7'h04,
    ST_INFRAME  = 7'h08,
    ST_MFA_SRCH = 7'h10,
    ST_CRC_CRC  = 7'h20,
    ST_CRC_NCI  = 7'h40
  } tda_state_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] slot;
    logic       data;
  } tda_mux_bit_t;

  typedef struct packed {
    logic data;
    logic fs;
    logic mfs;
  } tda_trib_word_t;

endpackage

// *** verilog/tda_fifo.sv ***
// synchronous fifo holding recovered tributary words
// assumes both sides on the same clock, synchronous active-low reset
module tda_fifo #(
  parameter int W     = 3,
  parameter int DEPTH = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_in,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_out,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr;
  logic [AW:0]  rd;
  logic [AW:0]  next_wr;
  logic [AW:0]  next_rd;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // ==========================================================
  // pointers
  always_comb
  begin
    full    = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
    empty   = (wr == rd);
    push    = i_in_valid && !full;
    pop     = i_out_ready && !empty;
    next_wr = push ? wr + 1'b1 : wr;
    next_rd = pop ? rd + 1'b1 : rd;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr <= '0;
      rd <= '0;
    end
    else
    begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end

  // ==========================================================
  // storage, no reset needed: read only when not empty
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr[AW-1:0]] <= i_in;
    end
  end

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out       = mem[rd[AW-1:0]];

endmodule

// *** verilog/tda_align.sv ***
// tributary demap alignment: slot select, frame and multiframe alignment, defects
// assumes the multiplex bits arrive on i_link_clk with justification resolved upstream,
// one selected tributary bit at most every fourth link cycle
// Summary of operation
// - after a tributary frequency step, recovery ends in bounded time, then error free.
// - only bits of the one configured tributary slot, one to four, are taken.
// - while not activated, output all ones and suppress every management report.
// - find the 250 us double frame and the 2 ms checksum multiframe phase.
// - both manual and automatic checksum interworking modes are supported.
// - with checksum setting off, multiframe present stays low.
// - with setting on, multiframe present rises only once multiframe alignment is found.
// - with setting auto, multiframe present is high only in checksum-to-checksum state.
// - frame loss defect is declared and cleared by the standard alignment procedure.
// - in auto mode, report when the far end does no checksum interworking.
// - all-ones defect uses X=2 periods of Y=512 bits with Z=3 zeros.
// - on either defect, raise insertion and server fail, output ones within 250 us.
// - report all-ones and frame loss faults with their correlation terms.
module tda_align
  import tda_pkg::*;
#(
  parameter int unsigned TRIB_SLOT = 1
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_link_clk,
  input  wire tda_pkg::tda_mux_bit_t i_mux,
  input  wire logic                  i_trail_signal_fail_in,
  input  wire logic                  i_function_activate,
  input  wire tda_pkg::tda_csm_t     i_checksum_multiframe_setting,
  input  wire logic                  i_all_ones_report_enable,
  input  wire logic                  i_trib_ready,
  output tda_pkg::tda_trib_word_t    o_trib,
  output logic                       o_trib_valid,
  output logic                       o_multiframe_present,
  output logic                       o_server_fail_action,
  output logic                       o_all_ones_insert_action,
  output logic                       o_all_ones_fault_report,
  output logic                       o_frame_loss_fault_report,
  output logic                       o_no_checksum_interworking,
  output logic                       o_frame_loss_defect,
  output logic                       o_all_ones_defect,
  output logic                       o_overrun
);
  import tda_pkg::*;

  localparam logic [1:0] SLOT_CODE = 2'(TRIB_SLOT - 1);

  function automatic logic is_fas(input logic [6:0] w);
    return w == FAS_WORD;
  endfunction

  // ==========================================================
  // link domain: slot select and event toggle
  logic lrst_s1;
  logic lrst_s2;
  logic ltog;
  logic lbit;
  logic next_ltog;
  logic next_lbit;

  always_comb
  begin
    next_ltog = ltog;
    next_lbit = lbit;
    if (i_mux.valid && (i_mux.slot == SLOT_CODE))
    begin
      next_ltog = !ltog;
      next_lbit = i_mux.data;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    lrst_s1 <= i_rst_n;
    lrst_s2 <= lrst_s1;
    if (!lrst_s2)
    begin
      ltog <= 1'b0;
      lbit <= 1'b1;
    end
    else
    begin
      ltog <= next_ltog;
      lbit <= next_lbit;
    end
  end

  // ==========================================================
  // crossing into the system domain
  // data is sampled one stage ahead of the edge detect; it holds for at least four link cycles
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic tog_s4;
  logic dat_s1;
  logic dat_s2;
  logic tsf_s1;
  logic tsf;
  logic bit_ev;
  logic bit_in;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      {tog_s1, tog_s2, tog_s3, tog_s4} <= 4'h0;
      {dat_s1, dat_s2, tsf_s1, tsf}    <= 4'hC;
    end
    else
    begin
      {tog_s1, tog_s2, tog_s3, tog_s4} <= {ltog, tog_s1, tog_s2, tog_s3};
      {dat_s1, dat_s2}                 <= {lbit, dat_s1};
      {tsf_s1, tsf}                    <= {i_trail_signal_fail_in, tsf_s1};
    end
  end

  assign bit_ev = tog_s3 ^ tog_s4;
  assign bit_in = dat_s2;

  // ==========================================================
  // frame and multiframe alignment
  tda_state_t     state;
  tda_state_t     next_state;
  logic [8:0]     pos;
  logic [8:0]     next_pos;
  logic [8:0]     cur;
  logic [7:0]     sh;
  logic [7:0]     next_sh;
  logic [1:0]     err;
  logic [1:0]     next_err;
  logic [5:0]     mfa;
  logic [5:0]     next_mfa;
  logic [2:0]     dbl;
  logic [2:0]     next_dbl;
  logic [5:0]     tmr;
  logic [5:0]     next_tmr;
  logic           mfp;
  logic           next_mfp;
  logic           in_frame;
  logic           csm_off;
  logic           insert;
  logic           take;
  logic           fifo_ready;
  logic           all_ones_defect;
  tda_trib_word_t word;

  assign take = bit_ev && fifo_ready;

  always_comb
  begin
    next_state = state;
    next_pos   = pos;
    next_sh    = sh;
    next_err   = err;
    next_mfa   = mfa;
    next_dbl   = dbl;
    next_tmr   = tmr;
    next_mfp   = mfp;
    cur        = pos + 9'h001;
    in_frame   = (state == ST_INFRAME) || (state == ST_MFA_SRCH) ||
                 (state == ST_CRC_CRC) || (state == ST_CRC_NCI);
    csm_off    = !((i_checksum_multiframe_setting == CSM_ON) ||
                   (i_checksum_multiframe_setting == CSM_AUTO));
    if (take)
    begin
      next_sh  = {sh[6:0], bit_in};
      next_pos = cur;
      unique case (state)
        ST_OOF:
        begin
          // free search restarts on every bit, so recovery time is bounded by three frames
          if (is_fas(next_sh[6:0]))
          begin
            next_pos   = POS_FAS_END;
            next_state = ST_NFAS_CHK;
          end
        end
        ST_NFAS_CHK:
        begin
          if (cur == POS_NFAS_B2)
          begin
            next_state = bit_in ? ST_FAS_CHK : ST_OOF;
          end
        end
        ST_FAS_CHK:
        begin
          if (cur == POS_FAS_END)
          begin
            next_err   = 2'h0;
            next_tmr   = 6'h00;
            next_mfa   = 6'h00;
            next_state = !is_fas(next_sh[6:0]) ? ST_OOF :
                         (csm_off ? ST_INFRAME : ST_MFA_SRCH);
          end
        end
        ST_INFRAME, ST_MFA_SRCH, ST_CRC_CRC, ST_CRC_NCI:
        begin
        end
        default:
        begin
          next_state = ST_OOF;
        end
      endcase
      if (cur == POS_DBL_START)
      begin
        // also runs out of frame, so a lost frame drops multiframe present at its next boundary
        next_mfp = !csm_off && (state == ST_CRC_CRC);
      end
      if (in_frame && (cur == POS_DBL_START))
      begin
        next_dbl = dbl + 3'h1;
        if (csm_off)
        begin
          next_state = ST_INFRAME;
        end
        else if ((state == ST_INFRAME) ||
                 ((state == ST_CRC_NCI) && (i_checksum_multiframe_setting == CSM_ON)))
        begin
          next_state = ST_MFA_SRCH;
          next_tmr   = 6'h00;
          next_mfa   = 6'h00;
        end
        else if (state == ST_MFA_SRCH)
        begin
          // manual mode keeps searching; auto gives up and assumes a non-checksum far end
          next_tmr = tmr + 6'h01;
          if ((i_checksum_multiframe_setting == CSM_AUTO) && (next_tmr == MFA_TIMEOUT_FRAMES))
          begin
            next_state = ST_CRC_NCI;
          end
        end
      end
      if ((state == ST_MFA_SRCH) && (cur == POS_NFAS_B1))
      begin
        next_mfa = {mfa[4:0], bit_in};
        if (next_mfa == MFAS_WORD)
        begin
          next_state = ST_CRC_CRC;
          next_dbl   = MFA_DBL_AT_MFAS;
        end
      end
      if (in_frame && (cur == POS_FAS_END))
      begin
        if (is_fas(next_sh[6:0]))
        begin
          next_err = 2'h0;
        end
        else if (err == FAS_LOSS_LIMIT - 2'h1)
        begin
          next_err   = 2'h0;
          next_state = ST_OOF;
        end
        else
        begin
          next_err = err + 2'h1;
        end
      end
    end
    insert    = all_ones_defect || !in_frame;
    word.data = (insert || !i_function_activate) ? 1'b1 : bit_in;
    word.fs   = in_frame && (cur == POS_DBL_START);
    word.mfs  = word.fs && (state == ST_CRC_CRC) && (next_dbl == 3'h0);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ST_OOF;
      pos   <= POS_RST;
      sh    <= 8'h00;
      err   <= 2'h0;
      mfa   <= 6'h00;
      dbl   <= 3'h0;
      tmr   <= 6'h00;
      mfp   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pos   <= next_pos;
      sh    <= next_sh;
      err   <= next_err;
      mfa   <= next_mfa;
      dbl   <= next_dbl;
      tmr   <= next_tmr;
      mfp   <= next_mfp;
    end
  end

  // ==========================================================
  // all-ones detection over consecutive 512-bit periods
  logic [8:0] acnt;
  logic [8:0] next_acnt;
  logic [1:0] zeros;
  logic [1:0] next_zeros;
  logic [1:0] lo;
  logic [1:0] next_lo;
  logic [1:0] hi;
  logic [1:0] next_hi;
  logic       next_all_ones_defect;
  logic [1:0] z;

  always_comb
  begin
    next_acnt  = acnt;
    next_zeros = zeros;
    next_lo    = lo;
    next_hi    = hi;
    next_all_ones_defect  = all_ones_defect;
    z          = (!bit_in && (zeros != AIS_Z)) ? zeros + 2'h1 : zeros;
    if (take)
    begin
      next_acnt  = acnt + 9'h001;
      next_zeros = z;
      if (acnt == AIS_Y_LAST)
      begin
        next_zeros = 2'h0;
        next_lo    = (z >= AIS_Z) ? 2'h0 : ((lo == AIS_X) ? lo : lo + 2'h1);
        next_hi    = (z < AIS_Z) ? 2'h0 : ((hi == AIS_X) ? hi : hi + 2'h1);
        if (next_lo == AIS_X)
        begin
          next_all_ones_defect = 1'b1;
        end
        else if (next_hi == AIS_X)
        begin
          next_all_ones_defect = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      acnt  <= 9'h000;
      zeros <= 2'h0;
      lo    <= 2'h0;
      hi    <= 2'h0;
      all_ones_defect  <= 1'b0;
    end
    else
    begin
      acnt  <= next_acnt;
      zeros <= next_zeros;
      lo    <= next_lo;
      hi    <= next_hi;
      all_ones_defect  <= next_all_ones_defect;
    end
  end

  // ==========================================================
  // consequent actions and fault reports
  logic [6:0] rep;
  logic [6:0] next_rep;

  always_comb
  begin
    next_rep[0] = insert;
    next_rep[1] = i_function_activate && all_ones_defect && !tsf && i_all_ones_report_enable;
    next_rep[2] = i_function_activate && !in_frame && !all_ones_defect && !tsf;
    next_rep[3] = i_function_activate && (i_checksum_multiframe_setting == CSM_AUTO) &&
                  (state == ST_CRC_NCI);
    next_rep[4] = !in_frame;
    next_rep[5] = all_ones_defect;
    next_rep[6] = bit_ev && !fifo_ready;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rep <= 7'h11;
    end
    else
    begin
      rep <= next_rep;
    end
  end

  assign o_all_ones_insert_action   = rep[0];
  assign o_server_fail_action       = rep[0];
  assign o_all_ones_fault_report    = rep[1];
  assign o_frame_loss_fault_report  = rep[2];
  assign o_no_checksum_interworking = rep[3];
  assign o_frame_loss_defect        = rep[4];
  assign o_all_ones_defect          = rep[5];
  assign o_overrun                  = rep[6];
  assign o_multiframe_present       = mfp;

  // ==========================================================
  // output buffer; a stalled drain drops bits and flags overrun
  tda_fifo #(
    .W     ($bits(tda_trib_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in        (word),
    .i_in_valid  (bit_ev),
    .o_in_ready  (fifo_ready),
    .o_out       (o_trib),
    .o_out_valid (o_trib_valid),
    .i_out_ready (i_trib_ready)
  );

  // ==========================================================
  // assertions
  a_slot_only_selected: assert property (@(posedge i_link_clk) disable iff (!lrst_s2)
    (ltog != $past(ltog)) |-> $past(i_mux.valid && (i_mux.slot == SLOT_CODE)))
    else $error("toggle without selected slot bit");
  a_inactive_ones: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && !i_function_activate) |-> word.data)
    else $error("data not all ones while inactive");
  a_insert_ones: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && (all_ones_defect || (state == ST_OOF))) |-> word.data ##1 o_all_ones_insert_action)
    else $error("defect without all ones insertion");
  a_mfp_off_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && in_frame && (cur == POS_DBL_START) && csm_off) |=> !mfp)
    else $error("multiframe present with setting off");
  a_mfp_needs_mfa: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(mfp) |-> $past(state == ST_CRC_CRC))
    else $error("multiframe present without alignment");
  a_mfp_nci_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take && (cur == POS_DBL_START) && (state == ST_CRC_NCI)) |=> !mfp)
    else $error("multiframe present in non-checksum state");
  a_mfp_boundary: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mfp != $past(mfp)) |-> $past(take && (cur == POS_DBL_START)))
    else $error("multiframe present changed off boundary");
  a_lof_three_errors: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($past(in_frame) && (state == ST_OOF)) |-> ($past(err) == 2'h2))
    else $error("frame loss without three bad alignment words");
  a_ais_period_end: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (all_ones_defect != $past(all_ones_defect)) |-> $past(take && (acnt == AIS_Y_LAST)))
    else $error("all ones defect changed inside a period");
  a_fault_reports: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_all_ones_fault_report || o_frame_loss_fault_report) |->
      $past(i_function_activate && !tsf) && !(o_all_ones_fault_report && o_frame_loss_fault_report))
    else $error("fault report correlation broken");
  a_nci_auto_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_no_checksum_interworking |-> $past(i_checksum_multiframe_setting == CSM_AUTO))
    else $error("no interworking report outside auto mode");

  c_crc_aligned: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(mfp));
  c_nci_state: cover property (@(posedge i_clk) disable iff (!i_rst_n) state == ST_CRC_NCI);
  c_ais_rise: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(all_ones_defect));
  c_overrun: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_overrun);

endmodule

// *** test/tda_mux_model.sv ***
// upstream multiplex model: four interleaved slots, one carries a framed stream
// assumes the bench reset; mode 0 checksum frames, 1 plain frames, 2 ones, 3 zeros
module tda_mux_model
  import tda_pkg::*;
(
  input  wire logic            i_link_clk,
  input  wire logic            i_rst_n,
  input  wire logic [1:0]      i_slot,
  input  wire logic [1:0]      i_mode,
  output tda_pkg::tda_mux_bit_t o_mux
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase;
  logic [8:0] pos;
  logic [2:0] dbl;
  logic [2:0] hold;
  logic       sbit;

  // ==========================================================
  // stream content
  always_comb
  begin
    // zero payload cannot fake a frame word
    sbit = 1'b0;
    if (pos >= 9'h001 && pos <= POS_FAS_END)
      sbit = FAS_WORD[7 - int'(pos)];
    else if (pos == POS_DBL_START || (pos > POS_NFAS_B1 && pos < 9'h108))
      sbit = 1'b1;
    else if (pos == POS_NFAS_B1)
      sbit = (i_mode != 2'h0 || dbl > 3'h5) ? 1'b1 : MFAS_WORD[5 - int'(dbl)];
    if (i_mode == 2'h2)
      sbit = 1'b1;
    else if (i_mode == 2'h3)
      sbit = 1'b0;
  end

  // ==========================================================
  // slot interleave, one bit of each slot in four link cycles
  always @(posedge i_link_clk)
  begin
    if (!i_rst_n)
    begin
      hold  <= 3'h0;
      phase <= 2'h0;
      pos   <= 9'h000;
      dbl   <= 3'h0;
      o_mux <= '0;
    end
    else if (hold != 3'h4)
      hold <= hold + 3'h1; // the link side of the block leaves reset late
    else
    begin
      phase       <= phase + 2'h1;
      o_mux.valid <= 1'b1;
      o_mux.slot  <= phase;
      o_mux.data  <= (phase == i_slot) ? sbit : ~sbit;
      if (phase == i_slot)
      begin
        pos <= pos + 9'h001;
        if (pos == 9'h1FF)
          dbl <= dbl + 3'h1;
      end
    end
  end
endmodule

// *** test/tributary_2m_demap_alignment_test.sv ***
// self-checking bench of the tributary demap alignment block
// assumes the multiplex model feeds slot 3 on a free link clock
module tributary_2m_demap_alignment_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tda_pkg::*;

  logic           i_clk;
  logic           i_rst_n;
  logic           link_clk;
  tda_mux_bit_t   mux;
  logic           tsf;
  logic           activate;
  tda_csm_t       setting;
  logic           ais_en;
  logic           trib_ready;
  logic [1:0]     mode;
  tda_trib_word_t o_trib;
  logic           o_trib_valid, o_mfp, o_ssf, o_ins, o_ais_rep, o_lof_rep, o_nci, o_lof, o_ais, o_ovr;
  int             errors;
  int             cmp_count;
  int             cyc;
  int             got;
  int             z;

  tda_mux_model i_model (.i_link_clk(link_clk), .i_rst_n(i_rst_n), .i_slot(2'h2), .i_mode(mode), .o_mux(mux));

  tda_align #(.TRIB_SLOT(3)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(link_clk), .i_mux(mux),
    .i_trail_signal_fail_in(tsf), .i_function_activate(activate),
    .i_checksum_multiframe_setting(setting), .i_all_ones_report_enable(ais_en),
    .i_trib_ready(trib_ready), .o_trib(o_trib), .o_trib_valid(o_trib_valid),
    .o_multiframe_present(o_mfp), .o_server_fail_action(o_ssf), .o_all_ones_insert_action(o_ins),
    .o_all_ones_fault_report(o_ais_rep), .o_frame_loss_fault_report(o_lof_rep),
    .o_no_checksum_interworking(o_nci), .o_frame_loss_defect(o_lof), .o_all_ones_defect(o_ais),
    .o_overrun(o_ovr));

  // ==========================================================
  // clocks, unrelated in phase
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // inputs change and outputs are read one unit after each edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  function automatic logic sel(input int k);
    case (k)
      0:       return o_lof;
      1:       return o_mfp;
      2:       return o_ais;
      3:       return o_nci;
      4:       return o_ovr;
      default: return o_lof_rep;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sel(k) !== v)
    begin
      if (n >= lim)
      begin
        errors++;
        tally_and_finish();
      end
      step(1);
      n++;
    end
  endtask

  // drain n words; frame starts must lie one double frame apart
  task automatic pop_words(input int n, output int zeros);
    int k;
    int gap;
    k = 0;
    gap = -1;
    zeros = 0;
    for (int c = 0; k < n; c++)
    begin
      if (c > 8 * n)
      begin
        errors++;
        tally_and_finish();
      end
      if (o_trib_valid === 1'b1)
      begin
        k++;
        if (o_trib.data !== 1'b1)
          zeros++;
        if (o_trib.mfs === 1'b1)
          check("mfs_on_fs", o_trib.fs, 1'b1);
        if (o_trib.fs === 1'b1 && gap >= 0)
          check("fs_gap", gap, 512);
        if (o_trib.fs === 1'b1)
          gap = 0;
        if (gap >= 0)
          gap++;
      end
      step(1);
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    errors = 0;
    cmp_count = 0;
    i_rst_n = 1'b0;
    tsf = 1'b0;
    activate = 1'b0;
    setting = CSM_AUTO;
    ais_en = 1'b1;
    trib_ready = 1'b0;
    mode = 2'h0;
    step(10);
    i_rst_n = 1'b1;
    step(1);
    check("frame_loss_defect", o_lof, 1'b1);
    check("insert_action", o_ins, 1'b1);
    check("frame_loss_report", o_lof_rep, 1'b0);
    // stalled drain: fifo fills until a bit is refused
    wait_sig(4, 1'b1, 2000, cyc);
    check("overrun_late", cyc >= 150, 1'b1);
    trib_ready = 1'b1;
    got = 0;
    z = 0;
    while (o_trib_valid === 1'b1 && got < 200)
    begin
      if (o_trib.data !== 1'b1)
        z++;
      got++;
      step(1);
    end
    check("drained_words", got >= FIFO_DEPTH && got < 200, 1'b1);
    check("inactive_zeros", z, 0);
    activate = 1'b1;
    step(3);
    check("frame_loss_report", o_lof_rep, 1'b1);
    wait_sig(0, 1'b0, 12000, cyc);
    pop_words(1200, z);
    check("payload_zeros", z > 1100, 1'b1);
    check("server_fail", o_ssf, 1'b0);
    check("frame_loss_report", o_lof_rep, 1'b0);
    wait_sig(1, 1'b1, 30000, cyc);
    check("nci", o_nci, 1'b0);
    setting = CSM_ON;
    step(2600);
    check("mfp_on", o_mfp, 1'b1);
    check("nci_on", o_nci, 1'b0);
    setting = CSM_OFF;
    wait_sig(1, 1'b0, 3000, cyc);
    mode = 2'h2;
    wait_sig(2, 1'b1, 8000, cyc);
    check("ais_delay", cyc >= 2400 && cyc <= 7500, 1'b1);
    step(3);
    check("insert_action", o_ins, 1'b1);
    check("server_fail", o_ssf, 1'b1);
    check("ais_report", o_ais_rep, 1'b1);
    check("frame_loss_report", o_lof_rep, 1'b0);
    check("mfp_off", o_mfp, 1'b0);
    ais_en = 1'b0;
    step(3);
    check("ais_report", o_ais_rep, 1'b0);
    ais_en = 1'b1;
    tsf = 1'b1;
    step(5);
    check("ais_report", o_ais_rep, 1'b0);
    tsf = 1'b0;
    mode = 2'h3;
    wait_sig(2, 1'b0, 8000, cyc);
    check("ais_clear_delay", cyc >= 2400, 1'b1);
    wait_sig(0, 1'b1, 10000, cyc);
    wait_sig(5, 1'b1, 10, cyc);
    pop_words(100, z);
    check("lof_zeros", z, 0);
    tsf = 1'b1;
    step(5);
    check("frame_loss_report", o_lof_rep, 1'b0);
    tsf = 1'b0;
    activate = 1'b0;
    step(3);
    check("frame_loss_report", o_lof_rep, 1'b0);
    activate = 1'b1;
    setting = CSM_AUTO;
    mode = 2'h1;
    wait_sig(0, 1'b0, 12000, cyc);
    wait_sig(3, 1'b1, 90000, cyc);
    check("nci_delay", cyc >= 75000, 1'b1);
    check("mfp_nci", o_mfp, 1'b0);
    tally_and_finish();
  end
endmodule
